/* File: src/mctl_consts.svh */
`ifndef MCTL_CONSTS_SVH
`define MCTL_CONSTS_SVH

// register byte offsets
`define MCTL_OFS_HW_CONFIG   8'h74
`define MCTL_OFS_TIMER_CFG   8'h8C
`define MCTL_OFS_TIMER_CNT   8'h90
`define MCTL_OFS_FREE_RUN    8'h9C
// field positions
`define MCTL_BIT_READY       27
`define MCTL_BIT_XOVER2      26
`define MCTL_BIT_XOVER1      25
`define MCTL_BIT_TIMER_EN    29
`define MCTL_PRELOAD_MSB     15
// reset values
`define MCTL_PRELOAD_RST     16'hFFFF
`define MCTL_COUNT_RST       16'hFFFF
`define MCTL_FREE_RST        32'h0000_0000
// timebase: 125 MHz core, 25 MHz counting tick
`define MCTL_CLK_MHZ         125
`define MCTL_TICK_MHZ        25
`define MCTL_TICK_DIV        (`MCTL_CLK_MHZ / `MCTL_TICK_MHZ)
// settle time before ready, in ns
`define MCTL_READY_NS        160
`define MCTL_CLK_NS          8
`define MCTL_READY_CYC       ((`MCTL_READY_NS + `MCTL_CLK_NS - 1) / `MCTL_CLK_NS)
`endif

/* File: src/mctl_pkg.sv */
package mctl_pkg;
  typedef logic [7:0]  mctl_addr_t;
  typedef logic [31:0] mctl_word_t;
  typedef enum logic [1:0] {
    MCTL_HALF_LOW  = 2'h1,
    MCTL_HALF_HIGH = 2'h2
  } mctl_half_t;
endpackage : mctl_pkg

/* File: src/mctl_top.sv */
`timescale 1ns/1ps
`include "mctl_consts.svh"
module mctl_top #(
  parameter int READY_CYC = `MCTL_READY_CYC
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // strap pins
  input  wire logic              xover_strap1_pin,
  input  wire logic              xover_strap2_pin,
  // loader rewrite of strap states
  input  wire logic              loader_we,
  input  wire logic              loader_xover1,
  input  wire logic              loader_xover2,
  // phy crossover override
  input  wire logic              crossover_override_ctrl1,
  input  wire logic              crossover_override_state1,
  input  wire logic              crossover_override_ctrl2,
  input  wire logic              crossover_override_state2,
  // register access
  input  wire logic              reg_rd,
  input  wire logic              reg_wr,
  input  wire mctl_pkg::mctl_addr_t reg_addr,
  input  wire mctl_pkg::mctl_word_t reg_wdata,
  output      mctl_pkg::mctl_word_t reg_rdata,
  // extended serial half read
  input  wire logic              half_rd,
  input  wire mctl_pkg::mctl_half_t half_sel,
  output      logic [15:0]       half_rdata,
  // interrupt enables and events
  input  wire logic              ready_irq_en,
  output      logic              ready_irq,
  output      logic              timer_irq,
  input  wire logic              timer_irq_clr
);
  import mctl_pkg::*;

  logic [1:0]  strap1_sync_reg;
  logic [1:0]  strap2_sync_reg;
  logic        xover1_reg;
  logic        xover2_reg;
  logic        ready_reg;
  logic [15:0] ready_cnt_reg;
  logic        timer_en_reg;
  logic        cfg_wr;
  logic [15:0] preload_reg;
  logic [15:0] count_reg;
  logic [31:0] free_reg;
  logic [2:0]  div_reg;
  logic        tick;
  logic        xover1_eff;
  logic        xover2_eff;
  logic        timer_en_next;
  mctl_word_t  hw_word;
  mctl_word_t  sel_word;

  function automatic mctl_word_t read_mux(input mctl_addr_t a);
    mctl_word_t w;
    w = '0;
    unique case (a)
      `MCTL_OFS_HW_CONFIG: w = hw_word;
      `MCTL_OFS_TIMER_CFG: begin
        w[`MCTL_BIT_TIMER_EN] = timer_en_reg;
        w[`MCTL_PRELOAD_MSB:0] = preload_reg;
      end
      `MCTL_OFS_TIMER_CNT: w[`MCTL_PRELOAD_MSB:0] = count_reg;
      `MCTL_OFS_FREE_RUN:  w = free_reg;
      default:             w = '0;
    endcase
    return w;
  endfunction : read_mux

  // strap synchronisers
  always_ff @(posedge mclk) begin
    strap1_sync_reg <= {strap1_sync_reg[0], xover_strap1_pin};
    strap2_sync_reg <= {strap2_sync_reg[0], xover_strap2_pin};
  end

  // strap latch while in reset, loader may rewrite later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      xover1_reg      <= strap1_sync_reg[1];
      xover2_reg      <= strap2_sync_reg[1];
    end else if (loader_we) begin
      xover1_reg <= loader_xover1;
      xover2_reg <= loader_xover2;
    end
  end

  assign xover1_eff = crossover_override_ctrl1 ? crossover_override_state1 : xover1_reg;
  assign xover2_eff = crossover_override_ctrl2 ? crossover_override_state2 : xover2_reg;

  // readiness after settle count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready_cnt_reg <= '0;
      ready_reg     <= 1'b0;
    end else if (!ready_reg) begin
      if (ready_cnt_reg >= 16'(READY_CYC - 1)) begin
        ready_reg <= 1'b1;
      end else begin
        ready_cnt_reg <= ready_cnt_reg + 16'h0001;
      end
    end
  end

  // pulse on ready rising, when enabled
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= ready_irq_en && !ready_reg &&
                   (ready_cnt_reg >= 16'(READY_CYC - 1));
    end
  end

  // 25 MHz tick divider
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (div_reg == 3'(`MCTL_TICK_DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  assign tick = (div_reg == 3'(`MCTL_TICK_DIV - 1));

  // free-running counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      free_reg <= `MCTL_FREE_RST;
    end else if (tick) begin
      free_reg <= free_reg + 32'h0000_0001;
    end
  end

  // timer_config writes, ignored until ready
  assign timer_en_next = reg_wdata[`MCTL_BIT_TIMER_EN];
  assign cfg_wr = reg_wr && ready_reg && (reg_addr == `MCTL_OFS_TIMER_CFG);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_en_reg <= 1'b0;
      preload_reg  <= `MCTL_PRELOAD_RST;
    end else if (cfg_wr) begin
      timer_en_reg <= timer_en_next;
      if (timer_en_reg && !timer_en_next) begin
        preload_reg <= `MCTL_PRELOAD_RST;
      end else begin
        preload_reg <= reg_wdata[`MCTL_PRELOAD_MSB:0];
      end
    end
  end

  // timer count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_reg <= `MCTL_COUNT_RST;
    end else if (cfg_wr && !timer_en_reg && timer_en_next) begin
      count_reg <= reg_wdata[`MCTL_PRELOAD_MSB:0];
    end else if (!timer_en_reg) begin
      count_reg <= preload_reg;
    end else if (tick) begin
      if (count_reg == 16'h0000) begin
        count_reg <= preload_reg;
      end else begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

  // timer interrupt flag, set wins over clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else if (timer_en_reg && tick && count_reg == 16'h0000) begin
      timer_irq <= 1'b1;
    end else if (timer_irq_clr) begin
      timer_irq <= 1'b0;
    end
  end

  // hardware_config readable at any time
  always_comb begin
    hw_word = '0;
    hw_word[`MCTL_BIT_READY]  = ready_reg;
    hw_word[`MCTL_BIT_XOVER2] = xover2_eff;
    hw_word[`MCTL_BIT_XOVER1] = xover1_eff;
  end

  // always_comb so the mux follows the registers it reads, not only the address
  always_comb begin
    sel_word = read_mux(reg_addr);
  end

  // read data registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= sel_word;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      half_rdata <= '0;
    end else if (half_rd) begin
      unique case (half_sel)
        MCTL_HALF_HIGH: half_rdata <= sel_word[31:16];
        MCTL_HALF_LOW:  half_rdata <= sel_word[15:0];
        default:        half_rdata <= '0;
      endcase
    end
  end
endmodule : mctl_top

/* File: verif/mctl_props.sv */
`timescale 1ns/1ps
module mctl_props (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // register access
  input wire logic                 reg_rd,
  input wire mctl_pkg::mctl_addr_t reg_addr,
  input wire mctl_pkg::mctl_word_t reg_rdata,
  input wire logic                 half_rd,
  input wire logic [15:0]          half_rdata,
  // interrupts
  input wire logic                 ready_irq_en,
  input wire logic                 ready_irq,
  input wire logic                 timer_irq,
  input wire logic                 timer_irq_clr
);
  import mctl_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence free_rd; reg_rd && reg_addr == 8'h9C; endsequence
  sequence free_pair; free_rd ##1 !reg_rd [*4] ##1 free_rd; endsequence
  AST_FREE_STEP: assert property (free_pair |=> reg_rdata == $past(reg_rdata) + 32'h1)
    else $error("free count step wrong");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  AST_HALF_HOLD: assert property (!half_rd |=> $stable(half_rdata))
    else $error("half data moved");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CNT_UPPER: assert property (reg_rd && reg_addr == 8'h90 |=> reg_rdata[31:16] == 16'h0)
    else $error("count upper bits set");
  AST_HW_RSVD: assert property (reg_rd && reg_addr == 8'h74 |=>
    reg_rdata[31:28] == 4'h0 && reg_rdata[24:0] == 25'h0) else $error("config reserved set");
  AST_RDY_PULSE: assert property (ready_irq |=> !ready_irq)
    else $error("ready pulse too long");
  AST_RDY_MASK: assert property (!ready_irq_en [*3] |-> !ready_irq)
    else $error("masked ready pulse");
  AST_TIRQ_STICKY: assert property (timer_irq && !timer_irq_clr |=> timer_irq)
    else $error("timer flag dropped");
endmodule : mctl_props

/* File: verif/mctl_host.sv */
`timescale 1ns/1ps
module mctl_host (
  // clock and answers
  input wire logic                 mclk,
  input wire mctl_pkg::mctl_word_t reg_rdata,
  input wire logic [15:0]          half_rdata,
  // requests
  output logic                     reg_rd,
  output logic                     reg_wr,
  output mctl_pkg::mctl_addr_t     reg_addr,
  output mctl_pkg::mctl_word_t     reg_wdata,
  output logic                     half_rd,
  output mctl_pkg::mctl_half_t     half_sel
);
  import mctl_pkg::*;
  initial begin
    {reg_rd, reg_wr, half_rd, reg_addr, reg_wdata} = '0;
    half_sel = MCTL_HALF_LOW;
  end
  task automatic rd(input mctl_addr_t a, output mctl_word_t d);
    @(negedge mclk) reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk) reg_rd = 1'b0;
    @(negedge mclk) d = reg_rdata;
  endtask : rd
  task automatic wr(input mctl_addr_t a, input mctl_word_t d);
    @(negedge mclk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge mclk) reg_wr = 1'b0;
  endtask : wr
  task automatic hrd(input mctl_addr_t a, input mctl_half_t s, output logic [15:0] d);
    @(negedge mclk) half_sel = s;
    reg_addr = a;
    half_rd = 1'b1;
    @(negedge mclk) half_rd = 1'b0;
    @(negedge mclk) d = half_rdata;
  endtask : hrd
endmodule : mctl_host

/* File: verif/mctl_top_tb.sv */
`timescale 1ns/1ps
module mctl_top_tb;
  import mctl_pkg::*;
  logic mclk = 0, rst_n = 0, xover_strap1_pin = 0, xover_strap2_pin = 0, loader_we = 0;
  logic loader_xover1 = 0, loader_xover2 = 0, ready_irq_en = 0, timer_irq_clr = 0;
  logic crossover_override_ctrl1 = 0, crossover_override_state1 = 0;
  logic crossover_override_ctrl2 = 0, crossover_override_state2 = 0;
  logic reg_rd, reg_wr, half_rd, ready_irq, timer_irq;
  logic [15:0] half_rdata, h;
  mctl_addr_t reg_addr;
  mctl_word_t reg_wdata, reg_rdata, v, w;
  mctl_half_t half_sel;
  int errors = 0, samples_checked = 0, pulses = 0, n;
  always #4 mclk = ~mclk;
  always @(negedge mclk) if (ready_irq === 1'b1) pulses++;
  mctl_top #(.READY_CYC(8)) mctl_top_inst (.mclk, .rst_n, .xover_strap1_pin, .xover_strap2_pin,
    .loader_we, .loader_xover1, .loader_xover2, .crossover_override_ctrl1,
    .crossover_override_state1, .crossover_override_ctrl2, .crossover_override_state2,
    .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .half_rd, .half_sel, .half_rdata,
    .ready_irq_en, .ready_irq, .timer_irq, .timer_irq_clr);
  mctl_host mctl_host_inst (.mclk, .reg_rdata, .half_rdata, .reg_rd, .reg_wr, .reg_addr,
    .reg_wdata, .half_rd, .half_sel);
  task automatic chk(input mctl_word_t got, input mctl_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic t_reset(input logic en, input logic s1, input logic s2);
    {ready_irq_en, xover_strap1_pin, xover_strap2_pin, rst_n} = {en, s1, s2, 1'b0};
    pulses = 0;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    mctl_host_inst.wr(8'h8C, 32'h2000_0003);
    mctl_host_inst.rd(8'h74, v);
    chk(v, {5'h00, s2, s1, 25'h0});
    repeat (8) @(negedge mclk);
    mctl_host_inst.rd(8'h74, v);
    chk(v, {5'h01, s2, s1, 25'h0});
    chk(32'(pulses), {31'h0, en});
    mctl_host_inst.rd(8'h8C, v);
    chk(v, 32'h0000_FFFF);
    mctl_host_inst.rd(8'h90, v);
    chk(v, 32'h0000_FFFF);
    mctl_host_inst.rd(8'h9C, v);
    repeat (2) @(negedge mclk);
    mctl_host_inst.rd(8'h9C, w);
    chk(w - v, 32'h1);
    mctl_host_inst.rd(8'h00, v);
    chk(v, 32'h0);
    mctl_host_inst.hrd(8'h74, MCTL_HALF_HIGH, h);
    chk({16'h0, h}, {16'h0, 5'h01, s2, s1, 9'h0});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_strap;
    {loader_xover1, loader_xover2, loader_we} = 3'b101;
    @(negedge mclk) loader_we = 1'b0;
    mctl_host_inst.rd(8'h74, v);
    chk(v, {5'h01, 2'b01, 25'h0});
    {crossover_override_ctrl1, crossover_override_ctrl2, crossover_override_state2} = 3'b111;
    mctl_host_inst.rd(8'h74, v);
    chk(v, {5'h01, 2'b10, 25'h0});
    {crossover_override_ctrl1, crossover_override_ctrl2} = 2'b00;
    $display("t_strap done");
  endtask : t_strap
  task automatic t_timer;
    mctl_host_inst.wr(8'h8C, 32'h2000_0003);
    mctl_host_inst.rd(8'h90, v);
    chk({31'h0, v <= 32'h3}, 32'h1);
    n = 0;
    while (timer_irq !== 1'b1 && n < 100) begin
      @(negedge mclk) n++;
    end
    timer_irq_clr = 1'b1;
    @(negedge mclk) timer_irq_clr = 1'b0;
    chk({31'h0, timer_irq}, 32'h0);
    n = 1;
    while (timer_irq !== 1'b1 && n < 100) begin
      @(negedge mclk) n++;
    end
    chk(32'(n), 32'd20);
    mctl_host_inst.wr(8'h8C, 32'h0000_0005);
    mctl_host_inst.rd(8'h8C, v);
    chk(v, 32'h0000_FFFF);
    mctl_host_inst.rd(8'h90, v);
    chk(v, 32'h0000_FFFF);
    $display("t_timer done");
  endtask : t_timer
  task automatic final_report;
    $display("checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    #20000;
    errors++;
    final_report;
  end
  initial begin
    t_reset(1'b1, 1'b1, 1'b0);
    t_strap;
    t_timer;
    t_reset(1'b0, 1'b0, 1'b1);
    final_report;
  end
endmodule : mctl_top_tb
bind mctl_top mctl_props mctl_props_inst (.mclk, .rst_n, .reg_rd, .reg_addr, .reg_rdata,
  .half_rd, .half_rdata, .ready_irq_en, .ready_irq, .timer_irq, .timer_irq_clr);
